// *** design/ebetc_pkg.sv ***
// Package: register map, field layout, divider table and shared types of the event timer block
package ebetc_pkg;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [15:0] EBETC_IDX_PORT1_LATCH = 16'hff01;
  localparam logic [15:0] EBETC_IDX_PORT3_LATCH = 16'hff03;
  localparam logic [15:0] EBETC_IDX_C0_COUNT = 16'hff16;
  localparam logic [15:0] EBETC_IDX_C0_COMPARE = 16'hff17;
  localparam logic [15:0] EBETC_IDX_C1_COUNT = 16'hff1f;
  localparam logic [15:0] EBETC_IDX_PORT1_DIR = 16'hff21;
  localparam logic [15:0] EBETC_IDX_PORT3_DIR = 16'hff23;
  localparam logic [15:0] EBETC_IDX_C1_COMPARE = 16'hff41;
  localparam logic [15:0] EBETC_IDX_C1_MODE = 16'hff43;
  localparam logic [15:0] EBETC_IDX_C0_CLKSEL = 16'hff6a;
  localparam logic [15:0] EBETC_IDX_C0_MODE = 16'hff6b;
  localparam logic [15:0] EBETC_IDX_C1_CLKSEL = 16'hff8c;
  localparam int EBETC_ADDR_W = 18;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] EBETC_CLKSEL_RST = 8'h00;
  localparam logic [7:0] EBETC_MODE_RST = 8'h00;
  localparam logic [7:0] EBETC_PORT1_DIR_RST = 8'hff;
  localparam logic [3:0] EBETC_PORT3_DIR_RST = 4'hf;
  localparam logic [7:0] EBETC_BYTE_ZERO = 8'h00;
  localparam int EBETC_C0_PIN_BIT = 7;
  localparam int EBETC_C1_PIN_BIT = 3;
  localparam logic [7:0] EBETC_COUNT_MAX = 8'hff;

  // ****************************************
  // Clock select codes and divider table
  // ****************************************
  localparam logic [2:0] EBETC_SEL_EXT_FALL = 3'h0;
  localparam logic [2:0] EBETC_SEL_EXT_RISE = 3'h1;
  localparam int EBETC_PRE_W = 13;
  // Log2 of the divider for codes 2..7, entry 0 is code 2
  localparam logic [5:0][3:0] EBETC_C0_SHIFT = {4'hd, 4'h8, 4'h6, 4'h2, 4'h1, 4'h0};
  localparam logic [5:0][3:0] EBETC_C1_SHIFT = {4'hc, 4'h8, 4'h6, 4'h4, 4'h1, 4'h0};

  localparam logic [1:0] EBETC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EBETC_RESP_DECERR = 2'h3;

  // Mode control byte, laid out bit for bit as software sees it
  typedef struct packed {
    logic run;
    logic pwm;
    logic [1:0] zero;
    logic ff_set;
    logic ff_clear;
    logic inv_pol;
    logic out_en;
  } ebetc_mode_t;

endpackage

// *** design/ebetc_top.sv ***
// Two 8-bit timer/event counters with their control registers behind an AXI4-Lite slave
//
// Summary of operation
// R01: Reset clears each clock select register
// R02: Counter 0 clock codes: edges or fx divisions
// R03: Counter 1 codes differ at 100 and 111
// R04: Software writes zero to clock select bits 7:3
// R05: Software stops counter before changing clock select
// R06: Reset clears mode control: stopped, disabled, match-clear
// R07: Run bit low clears and holds counter
// R08: Mode bit selects match-clear or PWM
// R09: Set/clear bits preset or clear output flip-flop
// R10: Set/clear bits ignored in PWM mode
// R11: Set/clear bits always read back zero
// R12: Bit 1 enables inversion or selects PWM level
// R13: Output enable low drives timer output low
// R14: Software avoids changing conflicting bit groups together
// R15: Software stops counter before changing mode bit
// R16: Stopping in PWM mode forces inactive output
// R17: Settings reach the pin even while stopped
// R18: Software sets pin direction and latch for use
// R19: Reset sets port direction registers all ones
// R20: Direction bit zero enables pin output buffer
// R21: Interval match clears counter and raises interrupt
// R22: Counter increments on selected clock, read-only
// R23: PWM active at overflow, inactive at match
// R24: PWM compare update takes effect at overflow
// R25: Two instances of one counter module, divider table set by CNT_ID
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module ebetc_counter
  import ebetc_pkg::*;
#(
  parameter int CNT_ID = 0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register access
  input wire logic wr_clksel_in,
  input wire logic wr_mode_in,
  input wire logic wr_cmp_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] clksel_out,
  output logic [7:0] mode_out,
  output logic [7:0] cmp_out,
  output logic [7:0] count_out,
  // Count sources
  input wire logic [EBETC_PRE_W-1:0] pre_in,
  input wire logic ext_in,
  // Timer output and match event
  output logic tout_out,
  output logic match_out
);

  if (CNT_ID != 0 && CNT_ID != 1) begin : g_bad_id
    $error("ebetc_counter: CNT_ID must be 0 or 1");
  end

  // ****************************************
  // Registers and count clock selection
  // ****************************************
  logic [2:0] clksel;
  ebetc_mode_t mode;
  logic [7:0] cmp;
  logic [7:0] cmp_act;
  logic [7:0] cnt;
  logic tff;
  logic pwm_ff;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;

  wire ebetc_mode_t wmode = ebetc_mode_t'(wdata_in);
  wire logic ext_rise = ext_s2 & ~ext_s3;
  wire logic ext_fall = ~ext_s2 & ext_s3;
  wire logic [2:0] div_code = clksel - 3'h2;
  wire logic [3:0] shift = (CNT_ID == 1) ? EBETC_C1_SHIFT[div_code] // [R03]
                                          : EBETC_C0_SHIFT[div_code]; // [R02]
  wire logic [EBETC_PRE_W-1:0] div_mask = EBETC_PRE_W'((14'h0001 << shift) - 14'h0001);
  wire logic div_tick = &(pre_in | ~div_mask);
  wire logic tick = (clksel == EBETC_SEL_EXT_FALL) ? ext_fall // [R02]
                  : (clksel == EBETC_SEL_EXT_RISE) ? ext_rise
                  : div_tick;
  wire logic step = mode.run & tick; // [R22]
  wire logic hit_clear = step & ~mode.pwm & (cnt == cmp);
  wire logic overflow = step & mode.pwm & (cnt == EBETC_COUNT_MAX);
  // Preset bits only act when the written byte keeps match-clear mode
  wire logic preset_go = wr_mode_in & ~wmode.pwm & (wmode.ff_set ^ wmode.ff_clear); // [R10]
  wire logic [7:0] next_cnt = hit_clear ? EBETC_BYTE_ZERO : cnt + 8'h01; // [R21]
  // Inactive as the count reaches the compare value, so the active width is N ticks
  wire logic hit_pwm = step & mode.pwm & (next_cnt == cmp_act); // [R23]
  wire logic pin_level = mode.pwm ? (pwm_ff ^ mode.inv_pol) : tff; // [R12]

  // The external input comes from a pin: two flops before any logic looks at it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clksel <= EBETC_CLKSEL_RST[2:0]; // [R01]
      mode <= ebetc_mode_t'(EBETC_MODE_RST); // [R06]
      cmp <= EBETC_BYTE_ZERO;
    end else begin
      if (wr_clksel_in) begin
        clksel <= wdata_in[2:0];
      end
      if (wr_mode_in) begin
        mode <= wmode;
      end
      if (wr_cmp_in) begin
        cmp <= wdata_in;
      end
    end
  end

  // ****************************************
  // Counter, output flip-flops, compare buffer
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= EBETC_BYTE_ZERO;
      match_out <= 1'b0;
    end else begin
      match_out <= hit_clear; // [R21]
      if (!mode.run) begin
        cnt <= EBETC_BYTE_ZERO; // [R07]
      end else if (step) begin
        cnt <= next_cnt; // [R08] [R22]
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tff <= 1'b0;
    end else if (preset_go) begin
      tff <= wmode.ff_set; // [R09]
    end else if (hit_clear && mode.inv_pol) begin
      tff <= ~tff; // [R12]
    end
  end

  // A compare write lands in the buffer; PWM only sees it at the next wrap, so a
  // half-updated period can never be emitted
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_act <= EBETC_BYTE_ZERO;
      pwm_ff <= 1'b0;
    end else begin
      if (!mode.pwm || !mode.run || overflow) begin
        cmp_act <= cmp; // [R24]
      end
      if (!mode.run) begin
        pwm_ff <= 1'b0; // [R16]
      end else if (overflow) begin
        pwm_ff <= 1'b1; // [R23]
      end else if (hit_pwm) begin
        pwm_ff <= 1'b0; // [R23]
      end
    end
  end

  // Output follows the settings one clock later, running or not
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tout_out <= 1'b0;
    end else begin
      tout_out <= mode.out_en & pin_level; // [R13] [R17]
    end
  end

  assign clksel_out = {5'h00, clksel}; // [R04]
  assign mode_out = {mode.run, mode.pwm, 2'h0, 2'h0, mode.inv_pol, mode.out_en}; // [R11]
  assign cmp_out = cmp;
  assign count_out = cnt;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_match_step;
    mode.run && !mode.pwm && tick && cnt == cmp;
  endsequence

  sequence s_cleared_with_event;
    cnt == EBETC_BYTE_ZERO && match_out;
  endsequence

  property p_stop_clears;
    @(posedge clk_in) disable iff (rst_in)
    !mode.run |=> cnt == EBETC_BYTE_ZERO;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not zero"); // [R07]

  property p_match_clear;
    @(posedge clk_in) disable iff (rst_in)
    s_match_step and (!wr_mode_in) |=> s_cleared_with_event;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear and flag"); // [R21]

  property p_count_up;
    @(posedge clk_in) disable iff (rst_in)
    step && !hit_clear && !wr_mode_in |=> cnt == $past(cnt) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not increment"); // [R22]

  property p_pwm_stop;
    @(posedge clk_in) disable iff (rst_in)
    mode.pwm && !mode.run && !wr_mode_in |=>
      !pwm_ff ##1 tout_out == ($past(mode.out_en) & $past(mode.inv_pol));
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("stopped PWM not inactive"); // [R16]

  property p_out_disabled;
    @(posedge clk_in) disable iff (rst_in)
    !mode.out_en |=> !tout_out;
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("disabled output not low"); // [R13]

  property p_preset;
    @(posedge clk_in) disable iff (rst_in)
    wr_mode_in && !wmode.pwm && wmode.ff_set && !wmode.ff_clear |=> tff;
  endproperty
  a_preset: assert property (p_preset) else $error("flip-flop preset lost"); // [R09]

  property p_pwm_ignores_preset;
    @(posedge clk_in) disable iff (rst_in)
    wr_mode_in && wmode.pwm |=> $stable(tff);
  endproperty
  a_pwm_ignores_preset: assert property (p_pwm_ignores_preset) else $error("preset in PWM"); // [R10]

  property p_overflow_active;
    @(posedge clk_in) disable iff (rst_in)
    overflow && !wr_mode_in |=> pwm_ff && cnt == EBETC_BYTE_ZERO && cmp_act == $past(cmp);
  endproperty
  a_overflow_active: assert property (p_overflow_active) else $error("overflow not active"); // [R23]

  property p_buffer_held;
    @(posedge clk_in) disable iff (rst_in)
    mode.pwm && mode.run && !overflow |=> cmp_act == $past(cmp_act);
  endproperty
  a_buffer_held: assert property (p_buffer_held) else $error("compare applied early"); // [R24]

  property p_preset_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
    wr_mode_in |=> mode_out[3:2] == 2'h0 && mode_out[7] == $past(wdata_in[7]);
  endproperty
  a_preset_reads_zero: assert property (p_preset_reads_zero) else $error("preset bits read"); // [R11]

endmodule

module ebetc_top
  import ebetc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite write channels
  input wire logic [EBETC_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [EBETC_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Shared pin of counter 0: count input or timer output
  input wire logic timer0_pin_in,
  output logic timer0_pin_out,
  output logic timer0_pin_oe_out,
  // Shared pin of counter 1
  input wire logic timer1_pin_in,
  output logic timer1_pin_out,
  output logic timer1_pin_oe_out,
  // Match interrupt requests
  output logic match0_out,
  output logic match1_out
);

  // ****************************************
  // Write channel
  // ****************************************
  logic [15:0] aw_idx;
  logic [7:0] wbyte;
  logic wbyte_en;
  logic [7:0] port1_dir;
  logic [3:0] port3_dir;
  logic [7:0] port1_latch;
  logic [3:0] port3_latch;
  logic [EBETC_PRE_W-1:0] pre;

  // Both halves held and no answer pending: perform the write this cycle
  wire logic write_go = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
  wire logic wr_ok = write_go & wbyte_en;
  wire logic hit_w_p1d = aw_idx == EBETC_IDX_PORT1_DIR;
  wire logic hit_w_p3d = aw_idx == EBETC_IDX_PORT3_DIR;
  wire logic hit_w_p1l = aw_idx == EBETC_IDX_PORT1_LATCH;
  wire logic hit_w_p3l = aw_idx == EBETC_IDX_PORT3_LATCH;
  wire logic hit_w_c0s = aw_idx == EBETC_IDX_C0_CLKSEL;
  wire logic hit_w_c0m = aw_idx == EBETC_IDX_C0_MODE;
  wire logic hit_w_c0c = aw_idx == EBETC_IDX_C0_COMPARE;
  wire logic hit_w_c1s = aw_idx == EBETC_IDX_C1_CLKSEL;
  wire logic hit_w_c1m = aw_idx == EBETC_IDX_C1_MODE;
  wire logic hit_w_c1c = aw_idx == EBETC_IDX_C1_COMPARE;
  wire logic hit_w_cnt = (aw_idx == EBETC_IDX_C0_COUNT) | (aw_idx == EBETC_IDX_C1_COUNT);
  wire logic w_mapped = hit_w_p1d | hit_w_p3d | hit_w_p1l | hit_w_p3l | hit_w_c0s
                      | hit_w_c0m | hit_w_c0c | hit_w_c1s | hit_w_c1m | hit_w_c1c | hit_w_cnt;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= EBETC_RESP_OKAY;
      aw_idx <= 16'h0000;
      wbyte <= EBETC_BYTE_ZERO;
      wbyte_en <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_idx <= s_axi_awaddr_in[EBETC_ADDR_W-1:2];
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wbyte <= s_axi_wdata_in[7:0];
        wbyte_en <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (write_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= w_mapped ? EBETC_RESP_OKAY : EBETC_RESP_DECERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // ****************************************
  // Port registers and prescaler
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port1_dir <= EBETC_PORT1_DIR_RST; // [R19]
      port3_dir <= EBETC_PORT3_DIR_RST; // [R19]
      port1_latch <= EBETC_BYTE_ZERO;
      port3_latch <= 4'h0;
    end else if (wr_ok) begin
      if (hit_w_p1d) begin
        port1_dir <= wbyte;
      end else if (hit_w_p3d) begin
        port3_dir <= wbyte[3:0];
      end else if (hit_w_p1l) begin
        port1_latch <= wbyte;
      end else if (hit_w_p3l) begin
        port3_latch <= wbyte[3:0];
      end
    end
  end

  // One free-running divider feeds both counters, so their divided clocks stay in phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre <= '0;
    end else begin
      pre <= pre + EBETC_PRE_W'(1);
    end
  end

  // ****************************************
  // Counter instances
  // ****************************************
  logic [7:0] c0_sel;
  logic [7:0] c0_mode;
  logic [7:0] c0_cmp;
  logic [7:0] c0_cnt;
  logic c0_tout;
  logic [7:0] c1_sel;
  logic [7:0] c1_mode;
  logic [7:0] c1_cmp;
  logic [7:0] c1_cnt;
  logic c1_tout;

  ebetc_counter #(.CNT_ID(0)) u_counter0 ( // [R25]
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_clksel_in(wr_ok & hit_w_c0s),
    .wr_mode_in(wr_ok & hit_w_c0m),
    .wr_cmp_in(wr_ok & hit_w_c0c),
    .wdata_in(wbyte),
    .clksel_out(c0_sel),
    .mode_out(c0_mode),
    .cmp_out(c0_cmp),
    .count_out(c0_cnt),
    .pre_in(pre),
    .ext_in(timer0_pin_in),
    .tout_out(c0_tout),
    .match_out(match0_out)
  );

  ebetc_counter #(.CNT_ID(1)) u_counter1 ( // [R25]
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_clksel_in(wr_ok & hit_w_c1s),
    .wr_mode_in(wr_ok & hit_w_c1m),
    .wr_cmp_in(wr_ok & hit_w_c1c),
    .wdata_in(wbyte),
    .clksel_out(c1_sel),
    .mode_out(c1_mode),
    .cmp_out(c1_cmp),
    .count_out(c1_cnt),
    .pre_in(pre),
    .ext_in(timer1_pin_in),
    .tout_out(c1_tout),
    .match_out(match1_out)
  );

  // Pin drives timer output merged with the latch; software keeps the latch at zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer0_pin_out <= 1'b0;
      timer0_pin_oe_out <= 1'b0;
      timer1_pin_out <= 1'b0;
      timer1_pin_oe_out <= 1'b0;
    end else begin
      timer0_pin_out <= c0_tout | port1_latch[EBETC_C0_PIN_BIT]; // [R18]
      timer0_pin_oe_out <= ~port1_dir[EBETC_C0_PIN_BIT]; // [R20]
      timer1_pin_out <= c1_tout | port3_latch[EBETC_C1_PIN_BIT]; // [R18]
      timer1_pin_oe_out <= ~port3_dir[EBETC_C1_PIN_BIT]; // [R20]
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  wire logic [15:0] ar_idx = s_axi_araddr_in[EBETC_ADDR_W-1:2];
  wire logic hit_r_p1d = ar_idx == EBETC_IDX_PORT1_DIR;
  wire logic hit_r_p3d = ar_idx == EBETC_IDX_PORT3_DIR;
  wire logic hit_r_p1l = ar_idx == EBETC_IDX_PORT1_LATCH;
  wire logic hit_r_p3l = ar_idx == EBETC_IDX_PORT3_LATCH;
  wire logic hit_r_c0s = ar_idx == EBETC_IDX_C0_CLKSEL;
  wire logic hit_r_c0m = ar_idx == EBETC_IDX_C0_MODE;
  wire logic hit_r_c0c = ar_idx == EBETC_IDX_C0_COMPARE;
  wire logic hit_r_c0n = ar_idx == EBETC_IDX_C0_COUNT;
  wire logic hit_r_c1s = ar_idx == EBETC_IDX_C1_CLKSEL;
  wire logic hit_r_c1m = ar_idx == EBETC_IDX_C1_MODE;
  wire logic hit_r_c1c = ar_idx == EBETC_IDX_C1_COMPARE;
  wire logic hit_r_c1n = ar_idx == EBETC_IDX_C1_COUNT;
  wire logic r_mapped = hit_r_p1d | hit_r_p3d | hit_r_p1l | hit_r_p3l | hit_r_c0s | hit_r_c0m
                      | hit_r_c0c | hit_r_c0n | hit_r_c1s | hit_r_c1m | hit_r_c1c | hit_r_c1n;
  wire logic [7:0] rbyte = hit_r_p1d ? port1_dir
                         : hit_r_p3d ? {4'h0, port3_dir}
                         : hit_r_p1l ? port1_latch
                         : hit_r_p3l ? {4'h0, port3_latch}
                         : hit_r_c0s ? c0_sel
                         : hit_r_c0m ? c0_mode
                         : hit_r_c0c ? c0_cmp
                         : hit_r_c0n ? c0_cnt
                         : hit_r_c1s ? c1_sel
                         : hit_r_c1m ? c1_mode
                         : hit_r_c1c ? c1_cmp
                         : hit_r_c1n ? c1_cnt
                         : EBETC_BYTE_ZERO;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= EBETC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= {24'h00_0000, rbyte};
        s_axi_rresp_out <= r_mapped ? EBETC_RESP_OKAY : EBETC_RESP_DECERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  property p_dir_drives_pin;
    @(posedge clk_in) disable iff (rst_in)
    !port1_dir[EBETC_C0_PIN_BIT] |=> timer0_pin_oe_out;
  endproperty
  a_dir_drives_pin: assert property (p_dir_drives_pin) else $error("pin buffer not enabled"); // [R20]

  property p_write_answer;
    @(posedge clk_in) disable iff (rst_in)
    write_go |=> s_axi_bvalid_out && !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule

`default_nettype wire

// *** testbench/ebetc_pin_model.sv ***
// Partner model: pulse source and load on one shared timer pin
`timescale 1ns/10ps
`default_nettype none

module ebetc_pin_model (
  // Clock
  input wire logic clk_in,
  // Device side of the pin
  input wire logic drv_in,
  input wire logic oe_in,
  // Resolved pin level
  output logic pin_out
);
  logic src;
  // The device wins the line only while its buffer is on
  assign pin_out = oe_in ? drv_in : src;
  initial src = 1'b0;
  // Phases of several cycles so the input synchroniser sees every edge
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      src <= 1'b1;
      repeat (4) @(posedge clk_in);
      src <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// *** testbench/eight_bit_event_timer_control_bench.sv ***
// Testbench: registers, clock codes, interval, event count and PWM
`timescale 1ns/10ps
`default_nettype none

module eight_bit_event_timer_control_bench;
  import ebetc_pkg::*;
  localparam logic [1:0][15:0] CS = {EBETC_IDX_C1_CLKSEL, EBETC_IDX_C0_CLKSEL};
  localparam logic [1:0][15:0] MD = {EBETC_IDX_C1_MODE, EBETC_IDX_C0_MODE};
  localparam logic [1:0][15:0] CP = {EBETC_IDX_C1_COMPARE, EBETC_IDX_C0_COMPARE};
  localparam logic [1:0][15:0] CN = {EBETC_IDX_C1_COUNT, EBETC_IDX_C0_COUNT};
  localparam int SH [2][6] = '{'{0, 1, 2, 6, 8, 13}, '{0, 1, 4, 6, 8, 12}};
  logic clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, p0_in, p1_in, p0_out, p1_out, p0_oe, p1_oe, m0, m1;
  logic [EBETC_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int n_errors = 0, compares = 0, cyc = 0, n;

  ebetc_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .timer0_pin_in(p0_in), .timer0_pin_out(p0_out),
    .timer0_pin_oe_out(p0_oe), .timer1_pin_in(p1_in), .timer1_pin_out(p1_out),
    .timer1_pin_oe_out(p1_oe), .match0_out(m0), .match1_out(m1));
  ebetc_pin_model i_pin0 (.clk_in(clk_in), .drv_in(p0_out), .oe_in(p0_oe), .pin_out(p0_in));
  ebetc_pin_model i_pin1 (.clk_in(clk_in), .drv_in(p1_out), .oe_in(p1_oe), .pin_out(p1_in));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bit a, w;
    a = 0;
    w = 0;
    awaddr <= {idx, 2'b00};
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk_in);
      if (awready) a = 1;
      if (wready) w = 1;
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(posedge clk_in);
    bready <= 1'b0;
    chk(32'(bresp), 32'(EBETC_RESP_OKAY));
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e,
                    input logic [1:0] er = EBETC_RESP_OKAY);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk_in);
    while (arready !== 1'b1) @(posedge clk_in);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_in);
    rready <= 1'b0;
    chk(rdata, 32'(e));
    chk(32'(rresp), 32'(er));
  endtask

  // Cycles from one match pulse to the next
  task automatic period(input int c, input int exp);
    n = 0;
    while ((c ? m1 : m0) !== 1'b1) @(posedge clk_in);
    do begin
      @(posedge clk_in);
      n++;
    end while ((c ? m1 : m0) !== 1'b1);
    chk(32'(n), 32'(exp));
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run needs some 25k cycles; the ceiling leaves ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0000_0000;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      rd(CS[c], 8'h00);
      rd(MD[c], 8'h00);
    end
    rd(EBETC_IDX_PORT1_DIR, 8'hff);
    rd(EBETC_IDX_PORT3_DIR, 8'h0f);
    chk(32'(p0_oe), 32'h0000_0000);
    rd(16'h0000, 8'h00, EBETC_RESP_DECERR);
    endt("reset");
    wr(EBETC_IDX_PORT1_DIR, 8'h7f);
    wr(MD[0], 8'h01);
    wr(MD[0], 8'h09);
    repeat (4) @(posedge clk_in);
    chk(32'(p0_out), 32'h0000_0001);
    rd(MD[0], 8'h01);
    wr(MD[0], 8'h05);
    repeat (4) @(posedge clk_in);
    chk(32'(p0_out), 32'h0000_0000);
    wr(MD[0], 8'h09);
    wr(MD[0], 8'h01);
    repeat (4) @(posedge clk_in);
    chk(32'(p0_out), 32'h0000_0001);
    wr(MD[0], 8'h00);
    repeat (4) @(posedge clk_in);
    chk(32'(p0_out), 32'h0000_0000);
    endt("preset");
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 6; k++) begin
        wr(MD[c], 8'h00);
        wr(CS[c], 8'(k + 2));
        wr(CP[c], 8'(k % 5));
        wr(MD[c], 8'h80);
        period(c, ((k % 5) + 1) << SH[c][k]);
      end
      wr(MD[c], 8'h00);
      rd(CN[c], 8'h00);
    end
    endt("clock select");
    wr(EBETC_IDX_PORT1_DIR, 8'hff);
    for (int e = 0; e < 2; e++) begin
      wr(CS[0], 8'(e));
      wr(CP[0], 8'hff);
      wr(MD[0], 8'h80);
      i_pin0.pulse(5);
      repeat (8) @(posedge clk_in);
      rd(CN[0], 8'h05);
      wr(MD[0], 8'h00);
    end
    endt("event count");
    wr(EBETC_IDX_PORT3_DIR, 8'h07);
    wr(CS[1], 8'h02);
    wr(CP[1], 8'h40);
    wr(MD[1], 8'h40);
    wr(MD[1], 8'h41);
    wr(MD[1], 8'hc1);
    chk(32'(p1_oe), 32'h0000_0001);
    while (p1_out !== 1'b1) @(posedge clk_in);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (p1_out === 1'b1);
    chk(32'(n), 32'h0000_0040);
    while (p1_out !== 1'b1) @(posedge clk_in);
    wr(MD[1], 8'h41);
    repeat (4) @(posedge clk_in);
    chk(32'(p1_out), 32'h0000_0000);
    wr(MD[1], 8'h43);
    repeat (4) @(posedge clk_in);
    chk(32'(p1_out), 32'h0000_0001);
    endt("pwm");
    give_verdict();
  end
endmodule

`default_nettype wire
